// ---- pkg/sebpg_defines.vh ----
`ifndef SEBPG_DEFINES_VH
`define SEBPG_DEFINES_VH
`define SEBPG_OP_EXT 2'h0
`define SEBPG_OP_WRITE 2'h1
`define SEBPG_OP_READ 2'h2
`define SEBPG_OP_ERASE 2'h3
`define SEBPG_EXT_LOCK 2'h0
`define SEBPG_EXT_BWRITE 2'h1
`define SEBPG_EXT_BERASE 2'h2
`define SEBPG_EXT_UNLOCK 2'h3
`define SEBPG_CNT_BYTE 5'h14
`define SEBPG_CNT_WORD 5'h1b
`define SEBPG_CNT_HDR_BYTE 5'h0c
`define SEBPG_CNT_HDR_WORD 5'h0b
`define SEBPG_ERASED 16'hffff
`define SEBPG_PROG_CYCLES 100000
`endif

// ---- verilog/sebpg_sync.v ----
`timescale 1ns/1ps
`default_nettype none
module sebpg_sync #(
    parameter W = 4
) (
    input wire core_clk,
    input wire rstn,
    input wire [W-1:0] async_in,
    output reg [W-1:0] sync_out
);
    reg [W-1:0] meta;
    always @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            meta <= {W{1'b0}};
            sync_out <= {W{1'b0}};
        end else begin
            meta <= async_in;
            sync_out <= meta;
        end
    end
endmodule
`default_nettype wire

// ---- verilog/sebpg_mem.v ----
`timescale 1ns/1ps
`default_nettype none
`include "sebpg_defines.vh"
module sebpg_mem #(
    parameter AW = 8,
    parameter DW = 16
) (
    input wire core_clk,
    input wire we,
    input wire [AW-1:0] waddr,
    input wire [DW-1:0] wdata,
    input wire [AW-1:0] raddr,
    output reg [DW-1:0] rdata
);
    reg [DW-1:0] mem [0:(1<<AW)-1];
    integer i;
    // Shipped state is all ones.
    initial begin
        for (i = 0; i < (1 << AW); i = i + 1) begin
            mem[i] = `SEBPG_ERASED;
        end
    end
    always @(posedge core_clk) begin
        if (we) begin
            mem[waddr] <= wdata;
        end
        rdata <= mem[raddr];
    end
endmodule
`default_nettype wire

// ---- verilog/sebpg_top.v ----
`timescale 1ns/1ps
`default_nettype none
`include "sebpg_defines.vh"
module sebpg_top #(
    parameter PROG_CYCLES = `SEBPG_PROG_CYCLES
) (
    // Clock and reset.
    input wire core_clk,
    input wire rstn,
    // Serial pins.
    input wire cs_pin,
    input wire sclk_pin,
    input wire sdi_pin,
    input wire org_pin,
    output reg sdo,
    output reg sdo_oe_n,
    // Handshake with the whole-array programming engine.
    output reg busy,
    output reg unlocked
);
    localparam ST_IDLE = 5'h01;
    localparam ST_SHIFT = 5'h02;
    localparam ST_ARMED = 5'h04;
    localparam ST_PROG = 5'h08;
    localparam ST_READY = 5'h10;

    // ==========================================================
    // Pin synchronisation and edge detection
    wire [3:0] pins;
    reg cs_d;
    reg clk_d;
    sebpg_sync #(.W(4)) u_sync (
        .core_clk(core_clk),
        .rstn(rstn),
        .async_in({org_pin, sdi_pin, sclk_pin, cs_pin}),
        .sync_out(pins)
    );
    wire cs = pins[0];
    wire sclk = pins[1];
    wire sdi = pins[2];
    wire word_org = pins[3];
    wire sclk_rise = sclk & ~clk_d;
    wire cs_fall = ~cs & cs_d;
    always @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            cs_d <= 1'b0;
            clk_d <= 1'b0;
        end else begin
            cs_d <= cs;
            clk_d <= sclk;
        end
    end

    // ==========================================================
    // Instruction shift path and pulse counter
    reg [4:0] state;
    reg [4:0] pulses;
    reg [26:0] shreg;
    reg [31:0] prog_cnt;
    reg [8:0] walk;
    reg op_erase_all;
    wire [4:0] hdr = word_org ? `SEBPG_CNT_HDR_WORD : `SEBPG_CNT_HDR_BYTE;
    wire [4:0] full = word_org ? `SEBPG_CNT_WORD : `SEBPG_CNT_BYTE;
    // Op-code and leading address bits sit at fixed spots after header.
    wire [1:0] opc = word_org ? shreg[9:8] : shreg[10:9];
    wire [1:0] ext = word_org ? shreg[7:6] : shreg[8:7];
    wire hdr_done = (pulses == hdr);
    wire [8:0] last_addr = word_org ? 9'h0ff : 9'h1ff;
    wire [15:0] word_data = shreg[15:0];
    wire [15:0] byte_data = {8'h00, shreg[7:0]};
    reg [15:0] fill;

    // ==========================================================
    // Array write port
    reg mem_we;
    reg [8:0] mem_addr;
    reg [15:0] mem_wdata;
    wire [15:0] mem_rdata;
    sebpg_mem #(.AW(9), .DW(16)) u_mem (
        .core_clk(core_clk),
        .we(mem_we),
        .waddr(mem_addr),
        .wdata(mem_wdata),
        .raddr(mem_addr),
        .rdata(mem_rdata)
    );

    // ==========================================================
    // Control state machine
    always @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            state <= ST_IDLE;
            pulses <= 5'h00;
            shreg <= 27'h0;
            prog_cnt <= 32'h0;
            walk <= 9'h000;
            op_erase_all <= 1'b0;
            fill <= 16'h0000;
            mem_we <= 1'b0;
            mem_addr <= 9'h000;
            mem_wdata <= 16'h0000;
            busy <= 1'b0;
            unlocked <= 1'b0;
        end else begin
            mem_we <= 1'b0;
            case (state)
                ST_IDLE: begin
                    if (cs && sclk_rise && sdi) begin
                        state <= ST_SHIFT;
                        pulses <= 5'h01;
                        shreg <= 27'h1;
                    end
                end
                ST_SHIFT: begin
                    if (!cs) begin
                        state <= ST_IDLE;
                    end else if (sclk_rise) begin
                        pulses <= pulses + 5'h01;
                        shreg <= {shreg[25:0], sdi};
                    end else if (hdr_done && opc == `SEBPG_OP_EXT) begin
                        if (ext == `SEBPG_EXT_UNLOCK) begin
                            unlocked <= 1'b1;
                            state <= ST_IDLE;
                        end else if (ext == `SEBPG_EXT_LOCK) begin
                            unlocked <= 1'b0;
                            state <= ST_IDLE;
                        end else if (ext == `SEBPG_EXT_BERASE) begin
                            state <= ST_ARMED;
                            op_erase_all <= 1'b1;
                        end else begin
                            state <= ST_ARMED;
                            op_erase_all <= 1'b0;
                        end
                    end else if (hdr_done) begin
                        state <= ST_IDLE;
                    end
                end
                ST_ARMED: begin
                    if (sclk_rise) begin
                        pulses <= pulses + 5'h01;
                        shreg <= {shreg[25:0], sdi};
                    end else if (cs_fall) begin
                        // Count and lock checked only here.
                        state <= ST_IDLE;
                        if (unlocked && ((op_erase_all && pulses == hdr)
                                || (!op_erase_all && pulses == full))) begin
                            state <= ST_PROG;
                            busy <= 1'b1;
                            prog_cnt <= 32'h0;
                            walk <= 9'h000;
                            fill <= op_erase_all ? `SEBPG_ERASED :
                                (word_org ? word_data : byte_data);
                        end
                    end
                end
                ST_PROG: begin
                    // Direct overwrite, no prior erase.
                    mem_we <= (walk != 9'h000) || (prog_cnt == 32'h0);
                    mem_addr <= walk;
                    mem_wdata <= fill;
                    if (walk != last_addr) begin
                        walk <= walk + 9'h001;
                    end
                    prog_cnt <= prog_cnt + 32'h1;
                    if (prog_cnt >= PROG_CYCLES - 1) begin
                        state <= ST_READY;
                        busy <= 1'b0;
                    end
                end
                ST_READY: begin
                    if (cs && sclk_rise && sdi) begin
                        state <= ST_SHIFT;
                        pulses <= 5'h01;
                        shreg <= 27'h1;
                    end else if (cs_fall) begin
                        state <= ST_IDLE;
                    end
                end
                default: begin
                    state <= ST_IDLE;
                end
            endcase
        end
    end

    // ==========================================================
    // Ready/busy output driver
    always @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            sdo <= 1'b1;
            sdo_oe_n <= 1'b1;
        end else begin
            sdo_oe_n <= 1'b1;
            sdo <= 1'b1;
            if (cs && state == ST_PROG) begin
                sdo_oe_n <= 1'b0;
                sdo <= 1'b0;
            end else if (cs && state == ST_READY) begin
                sdo_oe_n <= 1'b0;
                sdo <= 1'b1;
            end
        end
    end
endmodule
`default_nettype wire

// ---- testbench/sebpg_props.sv ----
`timescale 1ns/1ps
`default_nettype none
module sebpg_props #(
    parameter PROG_CYCLES = 600
) (
    input wire logic core_clk,
    input wire logic rstn,
    input wire logic cs_pin,
    input wire logic sdo,
    input wire logic sdo_oe_n,
    input wire logic busy,
    input wire logic unlocked
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (!rstn);
    logic [31:0] busy_cnt;
    always @(posedge core_clk or negedge rstn) begin
        if (!rstn)
            busy_cnt <= 32'h0;
        else
            busy_cnt <= busy ? busy_cnt + 32'h1 : 32'h0;
    end
    sequence s_busy_sel;
        (busy && cs_pin)[*6];
    endsequence
    sequence s_done_sel;
        ($fell(busy) && cs_pin) ##1 cs_pin[*6];
    endsequence
    property p_busy_out;
        s_busy_sel |-> !sdo_oe_n && !sdo;
    endproperty
    property p_ready;
        s_done_sel |-> sdo && !sdo_oe_n;
    endproperty
    property p_cs_low;
        (!cs_pin)[*6] |-> sdo_oe_n;
    endproperty
    property p_len;
        $fell(busy) |-> busy_cnt >= PROG_CYCLES - 1 && busy_cnt <= PROG_CYCLES + 1;
    endproperty
    property p_need_unlock;
        $rose(busy) |-> unlocked;
    endproperty
    property p_start_cs;
        $rose(busy) |-> !cs_pin;
    endproperty
    property p_lock_change;
        $changed(unlocked) |-> cs_pin && !busy;
    endproperty
    property p_busy_hold;
        busy && $past(busy) |-> $stable(unlocked);
    endproperty
    a_busy_out: assert property (p_busy_out) else $error("busy not shown");
    a_ready: assert property (p_ready) else $error("ready not shown");
    a_cs_low: assert property (p_cs_low) else $error("output not off");
    a_len: assert property (p_len) else $error("cycle length off");
    a_need_unlock: assert property (p_need_unlock) else $error("locked");
    a_start_cs: assert property (p_start_cs) else $error("early start");
    a_lock_change: assert property (p_lock_change) else $error("lock");
    a_busy_hold: assert property (p_busy_hold) else $error("not ignored");
endmodule
bind sebpg_top sebpg_props #(.PROG_CYCLES(PROG_CYCLES)) u_props (
    .core_clk(core_clk),
    .rstn(rstn),
    .cs_pin(cs_pin),
    .sdo(sdo),
    .sdo_oe_n(sdo_oe_n),
    .busy(busy),
    .unlocked(unlocked)
);
`default_nettype wire

// ---- testbench/sebpg_host.sv ----
`timescale 1ns/1ps
`default_nettype none
module sebpg_host (
    input wire logic core_clk,
    output logic cs_pin,
    output logic sclk_pin,
    output logic sdi_pin
);
    initial begin
        cs_pin = 1'b0;
        sclk_pin = 1'b0;
        sdi_pin = 1'b0;
    end
    task automatic tick(input int n);
        repeat (n) @(posedge core_clk);
    endtask
    task automatic set_cs(input logic v);
        @(posedge core_clk);
        cs_pin <= v;
    endtask
    // Each serial clock level lasts four core cycles, 800 ns a period.
    task automatic send(input logic [31:0] bits, input int n);
        set_cs(1'b1);
        tick(4);
        for (int i = n - 1; i >= 0; i--) begin
            sdi_pin <= bits[i];
            tick(4);
            sclk_pin <= 1'b1;
            tick(4);
            sclk_pin <= 1'b0;
        end
        tick(4);
        cs_pin <= 1'b0;
        sdi_pin <= ~sdi_pin;
        tick(8);
    endtask
endmodule
`default_nettype wire

// ---- testbench/tb.sv ----
`timescale 1ns/1ps
`default_nettype none
module tb;
    logic core_clk;
    logic rstn;
    logic org_pin;
    wire logic cs_pin;
    wire logic sclk_pin;
    wire logic sdi_pin;
    wire logic sdo;
    wire logic sdo_oe_n;
    wire logic busy;
    wire logic unlocked;
    initial begin
        core_clk = 1'b0;
        rstn = 1'b0;
        org_pin = 1'b1;
    end
    int failures = 0;
    int n_checks = 0;
    always #50 core_clk = ~core_clk;
    sebpg_host host (.core_clk(core_clk), .cs_pin(cs_pin),
        .sclk_pin(sclk_pin), .sdi_pin(sdi_pin));
    sebpg_top #(.PROG_CYCLES(600)) dut (.core_clk(core_clk), .rstn(rstn),
        .cs_pin(cs_pin), .sclk_pin(sclk_pin), .sdi_pin(sdi_pin),
        .org_pin(org_pin), .sdo(sdo), .sdo_oe_n(sdo_oe_n), .busy(busy),
        .unlocked(unlocked));
    task automatic chk(input logic got, input logic exp);
        n_checks++;
        if (got !== exp) begin
            failures++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic complete_run;
        $display("checks=%0d failures=%0d", n_checks, failures);
        if (failures == 0 && n_checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    task automatic wait_busy(input logic v, input int lim);
        for (int k = 0; k < lim && busy !== v; k++) host.tick(1);
        chk(busy, v);
        if (busy !== v) complete_run();
    endtask
    task automatic sc_locked;
        host.send(11'h480, 11);
        chk(busy, 1'b0);
    endtask
    task automatic sc_unlock;
        host.send(11'h4c0, 11);
        chk(unlocked, 1'b1);
    endtask
    task automatic sc_erase;
        host.send(11'h480, 11);
        wait_busy(1'b1, 20);
        host.send(11'h400, 11);
        host.set_cs(1'b1);
        host.tick(8);
        chk(sdo, 1'b0);
        chk(sdo_oe_n, 1'b0);
        wait_busy(1'b0, 700);
        host.tick(8);
        chk(sdo, 1'b1);
        chk(sdo_oe_n, 1'b0);
        chk(unlocked, 1'b1);
        host.set_cs(1'b0);
        host.tick(8);
        chk(sdo_oe_n, 1'b1);
    endtask
    task automatic sc_word_write;
        host.send({11'h440, 16'h5a3c, 1'b0}, 28);
        chk(busy, 1'b0);
        host.send({11'h440, 16'h5a3c}, 27);
        wait_busy(1'b1, 20);
        wait_busy(1'b0, 700);
    endtask
    task automatic sc_byte;
        @(posedge core_clk);
        org_pin <= 1'b0;
        host.send({12'h880, 8'ha5, 1'b1}, 21);
        chk(busy, 1'b0);
        host.send({12'h880, 8'ha5}, 20);
        wait_busy(1'b1, 20);
        wait_busy(1'b0, 700);
        host.send(12'h800, 12);
        chk(unlocked, 1'b0);
        host.send(12'h900, 12);
        chk(busy, 1'b0);
    endtask
    // A second reset mid-run must relock and release the output.
    task automatic sc_reset;
        host.send(12'h980, 12);
        chk(unlocked, 1'b1);
        @(posedge core_clk);
        rstn <= 1'b0;
        host.tick(2);
        chk(unlocked, 1'b0);
        chk(sdo_oe_n, 1'b1);
        rstn <= 1'b1;
        host.tick(3);
        host.send(12'h900, 12);
        chk(busy, 1'b0);
    endtask
    initial begin
        host.tick(2);
        rstn <= 1'b1;
        host.tick(3);
        sc_locked();
        sc_unlock();
        sc_erase();
        sc_word_write();
        sc_byte();
        sc_reset();
        complete_run();
    end
endmodule
`default_nettype wire
